// >>> pkg/ocf_params.svh
/*
 * Constants of the output configuration and fault coding block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 40 MHz core clock; included by the package only, the design uses its macros.
 */
`ifndef OCF_PARAMS_SVH
`define OCF_PARAMS_SVH

// ****************************************************************
// register map (byte addresses, one word each)
// ****************************************************************
`define OCF_ADR_SETUP2 8'h00
`define OCF_ADR_SETUP1 8'h04
`define OCF_ADR_STATUS 8'h08
`define OCF_ADR_SP_IDX 8'h0C
`define OCF_ADR_SP_DAT 8'h10
`define OCF_SETUP_RST 16'h0000

// ****************************************************************
// field positions
// ****************************************************************
`define OCF_S2_TYPE 14:13
`define OCF_S2_FMT 12
`define OCF_S2_TICK 11:8
`define OCF_S2_OD 7
`define OCF_S2_PAUSE 6:4
`define OCF_S2_POL 3
`define OCF_S2_FREQ 2:0
`define OCF_S1_DIGMODE 12
`define OCF_S1_BAND 7
`define OCF_S1_OVV 3
`define OCF_S1_LATCH 2
`define OCF_S1_DIAG 1
`define OCF_S1_LOCK 0
`define OCF_PAUSE_ON 3'b000
`define OCF_PAUSE_OFF 3'b101

// ****************************************************************
// timing
// ****************************************************************
`define OCF_CLK_NS 25
`define OCF_CLK_HZ 40000000
`define OCF_TICK_BASE_NS 500
`define OCF_TICK_STEP_NS 250
`define OCF_TICK_BASE_CYC (`OCF_TICK_BASE_NS / `OCF_CLK_NS)
`define OCF_TICK_STEP_CYC (`OCF_TICK_STEP_NS / `OCF_CLK_NS)
`define OCF_PWM_HZ0 2000
`define OCF_PWM_HZ1 1600
`define OCF_PWM_HZ2 1000
`define OCF_PWM_HZ3 800
`define OCF_PWM_HZ4 500
`define OCF_PWM_HZ5 400
`define OCF_PWM_HZ6 250
`define OCF_PWM_HZ7 200

// ****************************************************************
// fault duty cycles in per mille, linearization grid
// ****************************************************************
`define OCF_DUTY_DEN 1000
`define OCF_DUTY_SELF 950
`define OCF_DUTY_FLOW 625
`define OCF_DUTY_FHIGH 550
`define OCF_DUTY_OVV 750
`define OCF_DUTY_TEMP 850
`define OCF_DUTY_CLIP 700
`define OCF_SP_LAST 32
`define OCF_SP_SHIFT 10

`endif

// >>> pkg/ocf_pkg.sv
/*
 * Types of the output configuration and fault coding block.
 * Assumes ocf_params.svh sits on the include path.
 */
`include "ocf_params.svh"

package ocf_pkg;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic [7:0] adr;
		logic we;
		logic [3:0] sel;
		logic [31:0] dat;
		logic cyc;
		logic stb;
	} ocf_wb_req_s;

	typedef struct packed {
		logic selftest;
		logic field_low;
		logic field_high;
		logic ovv;
		logic temp;
		logic clip;
		logic undervolt;
		logic overtemp;
		logic sup_break;
		logic gnd_break;
		logic out_short;
	} ocf_flt_s;

	typedef struct packed {
		logic [1:0] sensor_type;
		logic fmt_h1;
		logic six_nibble;
		logic pause;
		logic [2:0] rate;
		logic [7:0] tick;
	} ocf_sent_s;

	typedef enum logic [2:0] {
		OCF_NONE = 3'h0,
		OCF_SELF = 3'h1,
		OCF_FLOW = 3'h2,
		OCF_FHIGH = 3'h3,
		OCF_OVV = 3'h4,
		OCF_TEMP = 3'h5,
		OCF_CLIP = 3'h6
	} ocf_code_e;

	// ****************************************************************
	// whole state of the top module
	// ****************************************************************
	typedef struct packed {
		logic [15:0] s1;
		logic [15:0] s2;
		logic [32:0][15:0] sp;
		logic [5:0] sp_idx;
		logic ack;
		logic [31:0] dat;
		ocf_flt_s flt_m;
		ocf_flt_s flt;
		ocf_flt_s lat;
		logic init;
		logic short_en;
		logic [19:0] cnt;
		logic [19:0] per;
		logic [19:0] on;
		ocf_code_e code;
		logic [15:0] lin;
		logic [15:0] ana;
		logic out;
		logic oe;
		ocf_sent_s cfg;
	} ocf_state_s;

endpackage : ocf_pkg

// >>> design/ocf_top.sv
/*
 * Output configuration and fault coding: setup registers over classic
 * Wishbone, SENT configuration decode, output linearization, PWM
 * generation with fault coding and the output pin driver.
 * Assumes fault inputs come from analog supervision (asynchronous),
 * POS_I and NV_LOCK_I come from logic on MCLK_I, and a SENT framer
 * outside consumes SENT_CFG_O.
 */
// How it works
// R1: short detection only after lock and reset
// R2: sensor type from bits 14:13
// R3: bit 12 picks secure or H1 format
// R4: tick is 0.5 us plus 0.25 us steps
// R5: bit 7 open-drain, wire break still active
// R6: pause code 000 on, 101 off
// R7: PWM period edge polarity from bit 3
// R8: bit 3 picks three or six nibbles
// R9: bits 2:0 set PWM or SENT rate
// R10: linear interpolation over equal segments
// R11: setpoints every 1024 up to 32768
// R12: analog error band on fault when enabled
// R13: over-temperature puts output in tristate
// R14: supply break low, ground break high
// R15: self-test errors: half frequency, 95 percent
// R16: field low 62.5, field high 55 percent
// R17: overvoltage 75 percent, or low if bit 7
// R18: temperature 85, clipping 70 percent
// R19: any coded error halves PWM frequency
// R20: undervoltage stops PWM, output held low
// R21: setup one bit 12 picks PWM or SENT
// R22: first fault in table order wins
// R23: no fault, unlatched: nominal at next period
`timescale 1ns/1ps

module ocf_top
	import ocf_pkg::*;
#(
	parameter int unsigned CLK_HZ = `OCF_CLK_HZ
)
(
	input wire logic MCLK_I,
	input wire logic RESET_N_I,
	input wire ocf_wb_req_s WB_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [15:0] POS_I,
	input wire logic NV_LOCK_I,
	input wire ocf_flt_s FAULT_I,
	output logic OUT_O,
	output logic OUT_OE_O,
	output ocf_sent_s SENT_CFG_O,
	output logic [15:0] ANALOG_O,
	output logic SHORT_DET_EN_O
);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d,
		input logic [3:0] s);
		return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction : merge16

	// nominal PWM period in clock cycles
	function automatic logic [19:0] nom_per(input logic [2:0] f);
		logic [19:0] p;
		case (f) // R9
			3'h0: p = 20'(CLK_HZ / `OCF_PWM_HZ0);
			3'h1: p = 20'(CLK_HZ / `OCF_PWM_HZ1);
			3'h2: p = 20'(CLK_HZ / `OCF_PWM_HZ2);
			3'h3: p = 20'(CLK_HZ / `OCF_PWM_HZ3);
			3'h4: p = 20'(CLK_HZ / `OCF_PWM_HZ4);
			3'h5: p = 20'(CLK_HZ / `OCF_PWM_HZ5);
			3'h6: p = 20'(CLK_HZ / `OCF_PWM_HZ6);
			default: p = 20'(CLK_HZ / `OCF_PWM_HZ7);
		endcase
		return p;
	endfunction : nom_per

	// high time as a per-mille share of a period
	function automatic logic [19:0] share(input logic [19:0] p, input logic [9:0] pm);
		return 20'((32'(p) * 32'(pm)) / 32'(`OCF_DUTY_DEN));
	endfunction : share

	ocf_state_s st;
	ocf_state_s nx;
	logic [15:0] lin_a;
	logic [15:0] lin_b;
	logic signed [16:0] lin_d;
	logic signed [27:0] lin_p;
	logic [15:0] lin_v;
	ocf_flt_s act;
	ocf_code_e code_v;
	logic diag_on;
	logic [19:0] per_v;
	logic pwm_lvl;
	logic lvl;
	logic en;
	logic [19:0] nom_now;

	// ****************************************************************
	// linearization
	// ****************************************************************

	// interpolate between the two setpoints around the input
	always_comb
	begin
		lin_a = st.sp[{1'b0, POS_I[14:10]}]; // R11
		lin_b = st.sp[6'({1'b0, POS_I[14:10]} + 6'h01)];
		lin_d = $signed({1'b0, lin_b}) - $signed({1'b0, lin_a});
		lin_p = lin_d * $signed({1'b0, POS_I[9:0]}); // R10
		lin_v = POS_I[15] ? st.sp[`OCF_SP_LAST]
			: 16'($signed({12'h000, lin_a}) + (lin_p >>> `OCF_SP_SHIFT)); // R10
	end

	// ****************************************************************
	// fault selection
	// ****************************************************************

	// coded faults seen by the output, latched ones included
	always_comb
	begin
		diag_on = !st.s1[`OCF_S1_DIAG];
		act = diag_on ? (st.flt | (st.s1[`OCF_S1_LATCH] ? st.lat : '0)) : '0;
		act.ovv = act.ovv & !st.s1[`OCF_S1_OVV];
		// table order decides among several faults
		code_v = act.selftest ? OCF_SELF
			: act.field_low ? OCF_FLOW
			: act.field_high ? OCF_FHIGH
			: act.ovv ? OCF_OVV
			: act.temp ? OCF_TEMP
			: act.clip ? OCF_CLIP : OCF_NONE; // R22
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		nx = st;
		nom_now = nom_per(st.s2[`OCF_S2_FREQ]);
		per_v = nom_now;
		// two-stage fault synchroniser
		nx.flt_m = FAULT_I;
		nx.flt = st.flt_m;
		nx.lat = st.lat | st.flt;
		nx.lin = lin_v;
		nx.init = 1'b1;
		if (!st.init)
		begin
			nx.short_en = NV_LOCK_I; // R1
		end

		// wishbone slave, answer one cycle after the request
		nx.ack = 1'b0;
		nx.dat = 32'h00000000;
		if (WB_I.cyc && WB_I.stb && !st.ack)
		begin
			nx.ack = 1'b1;
			case (WB_I.adr)
				`OCF_ADR_SETUP2:
				begin
					nx.dat = {16'h0000, st.s2};
					if (WB_I.we)
					begin
						nx.s2 = merge16(st.s2, WB_I.dat, WB_I.sel);
					end
				end
				`OCF_ADR_SETUP1:
				begin
					nx.dat = {16'h0000, st.s1};
					if (WB_I.we)
					begin
						nx.s1 = merge16(st.s1, WB_I.dat, WB_I.sel);
					end
				end
				`OCF_ADR_STATUS:
				begin
					nx.dat = {16'h0000, st.code, st.short_en, st.flt, st.s1[`OCF_S1_DIGMODE]};
				end
				`OCF_ADR_SP_IDX:
				begin
					nx.dat = {26'h0000000, st.sp_idx};
					if (WB_I.we && WB_I.sel[0])
					begin
						nx.sp_idx = WB_I.dat[5:0];
					end
				end
				`OCF_ADR_SP_DAT:
				begin
					if (st.sp_idx <= 6'(`OCF_SP_LAST))
					begin
						nx.dat = {16'h0000, st.sp[st.sp_idx]};
						if (WB_I.we)
						begin
							nx.sp[st.sp_idx] = merge16(st.sp[st.sp_idx], WB_I.dat, WB_I.sel);
						end
					end
				end
				default:
				begin
					nx.dat = 32'h00000000;
				end
			endcase
		end

		// SENT configuration decode
		nx.cfg.sensor_type = st.s2[`OCF_S2_TYPE]; // R2
		nx.cfg.fmt_h1 = st.s2[`OCF_S2_FMT]; // R3
		nx.cfg.six_nibble = st.s2[`OCF_S2_POL]; // R8
		nx.cfg.pause = (st.s2[`OCF_S2_PAUSE] == `OCF_PAUSE_ON); // R6
		nx.cfg.rate = st.s2[`OCF_S2_FREQ]; // R9
		nx.cfg.tick = 8'(`OCF_TICK_BASE_CYC + `OCF_TICK_STEP_CYC * st.s2[`OCF_S2_TICK]); // R4

		// analog value with error band
		nx.ana = st.lin;
		if (diag_on && code_v != OCF_NONE)
		begin
			nx.ana = st.s1[`OCF_S1_BAND] ? 16'h0000 : 16'hFFFF; // R12
		end

		// PWM period engine, fault code taken at the period boundary
		if (st.flt.undervolt)
		begin
			nx.cnt = 20'h00000; // R20
		end
		else if (st.cnt + 20'h00001 >= st.per)
		begin
			nx.cnt = 20'h00000;
			nx.code = code_v; // R23
			if (code_v != OCF_NONE)
			begin
				per_v = {nom_now[18:0], 1'b0}; // R19
			end
			nx.per = per_v;
			case (code_v)
				OCF_SELF: nx.on = share(per_v, 10'(`OCF_DUTY_SELF)); // R15
				OCF_FLOW: nx.on = share(per_v, 10'(`OCF_DUTY_FLOW)); // R16
				OCF_FHIGH: nx.on = share(per_v, 10'(`OCF_DUTY_FHIGH)); // R16
				OCF_OVV: nx.on = share(per_v, 10'(`OCF_DUTY_OVV)); // R17
				OCF_TEMP: nx.on = share(per_v, 10'(`OCF_DUTY_TEMP)); // R18
				OCF_CLIP: nx.on = share(per_v, 10'(`OCF_DUTY_CLIP)); // R18
				default: nx.on = 20'((32'(per_v) * 32'(st.lin[15:4])) >> 12);
			endcase
		end
		else
		begin
			nx.cnt = st.cnt + 20'h00001;
		end

		// period opens low (falling edge) or high (rising edge)
		pwm_lvl = st.s2[`OCF_S2_POL] ? (st.cnt < st.on)
			: (st.cnt >= st.per - st.on); // R7

		// pin level by priority of the always-active supervision
		en = 1'b1;
		lvl = pwm_lvl;
		if (st.flt.overtemp)
		begin
			en = 1'b0; // R13
		end
		else if (st.flt.sup_break)
		begin
			lvl = 1'b0; // R14
		end
		else if (st.flt.gnd_break)
		begin
			lvl = 1'b1; // R14
		end
		else if (st.flt.undervolt)
		begin
			lvl = 1'b0; // R20
		end
		else if (st.short_en && st.flt.out_short)
		begin
			en = 1'b0; // R1
		end
		else if (st.s1[`OCF_S1_DIGMODE])
		begin
			lvl = 1'b1; // R21
		end
		else if (act.ovv && st.s1[`OCF_S1_BAND])
		begin
			lvl = 1'b0; // R17
		end
		// open drain only sinks, so a high is a release
		nx.out = lvl && !st.s2[`OCF_S2_OD]; // R5
		nx.oe = st.s2[`OCF_S2_OD] ? (en && !lvl) : en; // R5
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge MCLK_I)
	begin
		if (!RESET_N_I)
		begin
			st <= '0;
			st.s1 <= `OCF_SETUP_RST;
			st.s2 <= `OCF_SETUP_RST;
		end
		else
		begin
			st <= nx;
		end
	end

	// outputs straight from the state
	assign WB_DAT_O = st.dat;
	assign WB_ACK_O = st.ack;
	assign OUT_O = st.out;
	assign OUT_OE_O = st.oe;
	assign SENT_CFG_O = st.cfg;
	assign ANALOG_O = st.ana;
	assign SHORT_DET_EN_O = st.short_en;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	property p_short_fixed;
		$past(st.init) |-> $stable(SHORT_DET_EN_O);
	endproperty
	a_short_fixed: assert property (p_short_fixed) else $error("short enable moved"); // R1

	property p_sent_fields;
		1 |=> SENT_CFG_O.sensor_type == $past(st.s2[14:13])
			&& SENT_CFG_O.fmt_h1 == $past(st.s2[12]) && SENT_CFG_O.six_nibble == $past(st.s2[3]);
	endproperty
	a_sent_fields: assert property (p_sent_fields) else $error("sent fields wrong"); // R2

	property p_tick;
		st.s2[11:8] == 4'hF ##1 $stable(st.s2) |=> SENT_CFG_O.tick == 8'd170;
	endproperty
	a_tick: assert property (p_tick) else $error("tick count wrong"); // R4

	property p_od;
		st.s2[7] |=> !OUT_O;
	endproperty
	a_od: assert property (p_od) else $error("open drain drove high"); // R5

	property p_pause;
		st.s2[6:4] == 3'b101 |=> !SENT_CFG_O.pause;
	endproperty
	a_pause: assert property (p_pause) else $error("pause left on"); // R6

	property p_half;
		!st.flt.undervolt && st.cnt + 20'h00001 >= st.per && code_v != OCF_NONE
			|=> st.per == {$past(nom_now[18:0]), 1'b0};
	endproperty
	a_half: assert property (p_half) else $error("error period not doubled"); // R19

	property p_overtemp;
		st.flt.overtemp |=> !OUT_OE_O;
	endproperty
	a_overtemp: assert property (p_overtemp) else $error("output driven in overtemp"); // R13

	property p_sup_break;
		st.flt.sup_break && !st.flt.overtemp |=> OUT_OE_O && !OUT_O;
	endproperty
	a_sup_break: assert property (p_sup_break) else $error("supply break not low"); // R14

	property p_uv;
		st.flt.undervolt && !st.flt.overtemp && !st.flt.sup_break && !st.flt.gnd_break
			|=> OUT_OE_O && !OUT_O && st.cnt == 20'h00000;
	endproperty
	a_uv: assert property (p_uv) else $error("undervolt not held low"); // R20

	property p_band;
		diag_on && code_v != OCF_NONE |=> ANALOG_O == ($past(st.s1[7]) ? 16'h0000 : 16'hFFFF);
	endproperty
	a_band: assert property (p_band) else $error("error band missing"); // R12

	property p_ack;
		WB_I.cyc && WB_I.stb && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack timing wrong");

	c_coded: cover property (st.cnt == 20'h00000 && st.code == OCF_SELF);
	c_sent: cover property (st.s1[12] && SENT_CFG_O.six_nibble);
	c_short: cover property (st.short_en && st.flt.out_short && !OUT_OE_O);
	c_write: cover property (WB_I.we && WB_ACK_O);

endmodule : ocf_top

// >>> verif/ocf_ecu_model.sv
/*
 * Receiving control unit model: measures period and high time of the pin.
 * Assumes a pull-up on the line and the bench clock on clk_i.
 */
`timescale 1ns/1ps

// ****************************************************************
// pulse receiver
// ****************************************************************
module ocf_ecu_model
(
	input wire logic clk_i,
	input wire logic out_i,
	input wire logic oe_i,
	output logic line_o,
	output int per_o,
	output int high_o,
	output int rise_o
);
	int cnt = 0;
	logic last = 1'b1;

	// released line floats to the pull-up level
	assign line_o = oe_i ? out_i : 1'b1;

	// period from rise to rise, high time from rise to fall
	always @(posedge clk_i)
	begin
		cnt <= cnt + 1;
		last <= line_o;
		if (line_o && !last)
		begin
			per_o <= cnt;
			rise_o <= rise_o + 1;
			cnt <= 1;
		end
		if (!line_o && last)
			high_o <= cnt;
	end
endmodule : ocf_ecu_model

// >>> verif/ocf_top_tb.sv
/*
 * Self-checking bench of ocf_top: registers over Wishbone, SENT decode,
 * PWM timing, fault coding and pin states.
 * Assumes ocf_pkg compiled first and ocf_ecu_model on the pin.
 */
`timescale 1ns/1ps

module ocf_top_tb
	import ocf_pkg::*;
;
	// ****************************************************************
	// signals, counters
	// ****************************************************************
	localparam int HZ = 400000;
	logic clk, rst_n, lock, line;
	ocf_wb_req_s wb_req;
	ocf_flt_s flt;
	logic [15:0] pos, v;
	logic [31:0] q, WB_DAT_O;
	logic WB_ACK_O, OUT_O, OUT_OE_O, SHORT_DET_EN_O;
	ocf_sent_s SENT_CFG_O;
	logic [15:0] ANALOG_O;
	int err_total, compares, cyc, per, high, rise, p, h, f, lin, pv;
	int hz[8] = '{2000, 1600, 1000, 800, 500, 400, 250, 200};
	int pm[7] = '{950, 625, 550, 750, 850, 700, 950};
	logic [10:0] cm[7] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h040, 11'h020, 11'h420};
	logic [10:0] pmk[4] = '{11'h008, 11'h004, 11'h002, 11'h010};
	logic lv[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	ocf_top #(.CLK_HZ(HZ)) ocf_top_i (.MCLK_I(clk), .RESET_N_I(rst_n), .WB_I(wb_req),
		.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .POS_I(pos), .NV_LOCK_I(lock),
		.FAULT_I(flt), .OUT_O(OUT_O), .OUT_OE_O(OUT_OE_O), .SENT_CFG_O(SENT_CFG_O),
		.ANALOG_O(ANALOG_O), .SHORT_DET_EN_O(SHORT_DET_EN_O));
	ocf_ecu_model ocf_ecu_model_i (.clk_i(clk), .out_i(OUT_O), .oe_i(OUT_OE_O),
		.line_o(line), .per_o(per), .high_o(high), .rise_o(rise));

	// clock and watchdog
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			err_total++;
			stop_test();
		end
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic stop_test;
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s exp %0h got %0h", n, e, g);
		end
	endtask : chk

	task automatic chk_near(input string n, input int e, input int g, input int tol);
		compares++;
		if ((g > e ? g - e : e - g) > tol)
		begin
			err_total++;
			$display("[ERR] %s exp %0d got %0d", n, e, g);
		end
	endtask : chk_near

	// classic single cycle, held until ack is sampled
	task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d);
		wb_req <= '{adr: a, we: w, sel: 4'hF, dat: {16'h0, d}, cyc: 1'b1, stb: 1'b1};
		@(posedge clk);
		while (WB_ACK_O !== 1'b1)
			@(posedge clk);
		q = WB_DAT_O;
		wb_req <= '0;
		@(posedge clk);
	endtask : wb

	task automatic reset(input logic l);
		rst_n <= 1'b0;
		lock <= l;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : reset

	task automatic meas;
		int r0;
		r0 = rise;
		while (rise - r0 < 4)
			@(posedge clk);
		p = per;
		h = high;
	endtask : meas

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		rst_n = 1'b0;
		lock = 1'b0;
		wb_req = '0;
		flt = '0;
		pos = 16'h4000;
		void'($urandom(44686));
		reset(1'b0);
		// reset values, unmapped place, short detection unarmed
		wb(8'h00, 1'b0, 16'h0);
		chk("setup2_rst", 32'h0, q);
		wb(8'h04, 1'b0, 16'h0);
		chk("setup1_rst", 32'h0, q);
		wb(8'h20, 1'b1, 16'hFFFF);
		wb(8'h20, 1'b0, 16'h0);
		chk("unmapped", 32'h0, q);
		flt <= ocf_flt_s'(11'h001);
		repeat (6) @(posedge clk);
		chk("short_unarmed", 32'h1, {31'h0, OUT_OE_O});
		flt <= '0;
		// SENT field decode, corners then random
		for (int i = 0; i < 14; i++)
		begin
			v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h7FD7 : 16'($urandom);
			v[6:4] = v[15] ? 3'b000 : 3'b101;
			v[15] = 1'b0;
			wb(8'h00, 1'b1, v);
			wb(8'h00, 1'b0, 16'h0);
			chk("setup2_rd", {16'h0, v}, q);
			chk("sent_cfg", {v[14:13], v[12], v[3], v[6:4] == 3'b000, v[2:0],
				8'(20 + 10 * v[11:8])}, {16'h0, SENT_CFG_O});
		end
		// setpoints on a 1.5 slope
		for (int i = 0; i < 33; i++)
		begin
			wb(8'h0C, 1'b1, 16'(i));
			wb(8'h10, 1'b1, 16'(i * 1536));
		end
		wb(8'h10, 1'b0, 16'h0);
		chk("sp_last", 32'hC000, q);
		// nominal PWM from linearized position
		repeat (4)
		begin
			f = $urandom % 4;
			pv = 4096 + $urandom % 28672;
			pos <= 16'(pv);
			wb(8'h00, 1'b1, 16'({$urandom % 2, f[2:0]}));
			meas();
			lin = (pv * 3) >> 1;
			chk("analog", 32'(lin), {16'h0, ANALOG_O});
			chk_near("period", HZ / hz[f], p, 1);
			chk_near("high", (HZ / hz[f]) * (lin >> 4) / 4096, h, 2);
		end
		// coded faults, last entry two at once
		for (int k = 0; k < 7; k++)
		begin
			f = $urandom % 2;
			wb(8'h00, 1'b1, 16'({$urandom % 2, f[2:0]}));
			flt <= ocf_flt_s'(cm[k]);
			meas();
			chk_near("flt_period", 2 * HZ / hz[f], p, 1);
			chk_near("flt_high", 2 * HZ / hz[f] * pm[k] / 1000, h, 2);
			flt <= '0;
			meas();
			chk_near("clr_period", HZ / hz[f], p, 1);
		end
		// error band and overvoltage low
		flt <= ocf_flt_s'(11'h400);
		repeat (6) @(posedge clk);
		chk("band_hi", 32'hFFFF, {16'h0, ANALOG_O});
		wb(8'h04, 1'b1, 16'h0080);
		repeat (4) @(posedge clk);
		chk("band_lo", 32'h0, {16'h0, ANALOG_O});
		flt <= ocf_flt_s'(11'h080);
		repeat (1000) @(posedge clk);
		f = rise;
		repeat (1000) @(posedge clk);
		chk("ovv_rises", 32'(f), 32'(rise));
		chk("ovv_low", 32'h0, {31'h0, line});
		// pin faults, push-pull then open drain
		for (int od = 0; od < 2; od++)
		begin
			wb(8'h00, 1'b1, od ? 16'h0080 : 16'h0000);
			for (int k = 0; k < 4; k++)
			begin
				flt <= ocf_flt_s'(pmk[k]);
				repeat (6) @(posedge clk);
				chk("pin_lvl", {31'h0, lv[k]}, {31'h0, line});
				chk("pin_oe", (k == 0 || (od && lv[k])) ? 32'h0 : 32'h1,
					{31'h0, OUT_OE_O});
			end
		end
		// SENT mode idles high
		flt <= '0;
		wb(8'h00, 1'b1, 16'h0008);
		wb(8'h04, 1'b1, 16'h1000);
		repeat (8) @(posedge clk);
		chk("sent_idle", 32'h3, {30'h0, OUT_O, OUT_OE_O});
		// lock then reset arms short detection
		reset(1'b1);
		chk("short_armed", 32'h1, {31'h0, SHORT_DET_EN_O});
		flt <= ocf_flt_s'(11'h001);
		repeat (6) @(posedge clk);
		chk("short_tri", 32'h0, {31'h0, OUT_OE_O});
		wb(8'h08, 1'b0, 16'h0);
		chk("status", 32'h1002, q);
		stop_test();
	end
endmodule : ocf_top_tb
